// >>> rtl/aisel_pkg.sv
// constants and types for the card address and interrupt select block
package aisel_pkg;
  localparam int ADDR_W      = 6;
  localparam int BUS_W       = 16;
  localparam int SB_W        = 16;
  localparam int SB_SEL_W    = 4;
  localparam int VEC_GATES   = 4;
  localparam int GATE_SEL_W  = 4;
  localparam logic [ADDR_W-1:0] ADDR_DEFAULT = 6'h35;
  localparam logic [SB_SEL_W-1:0] SB_DEFAULT = 4'h0;
  typedef enum logic [1:0] {
    AISEL_IDLE    = 2'b00,
    AISEL_PENDING = 2'b01,
    AISEL_ACKED   = 2'b11
  } aisel_state_t;
endpackage

// >>> rtl/aisel_if.sv
// strap set shared between the top and the vector generator
`timescale 1ns/10ps
interface aisel_if;
  import aisel_pkg::*;
  logic [VEC_GATES-1:0]  gate_used;
  logic [GATE_SEL_W-1:0] gate_line [VEC_GATES];
  logic [BUS_W-1:0]      vector;
  modport top (output gate_used, output gate_line, input vector);
  modport gen (input gate_used, input gate_line, output vector);
endinterface

// >>> rtl/aisel_vecgen.sv
// interrupt vector generator: up to four strapped ones on the data bus
`timescale 1ns/10ps
module aisel_vecgen
  import aisel_pkg::*;
(
  aisel_if.gen straps
);
  always_comb begin
    straps.vector = '0;
    for (int g = 0; g < VEC_GATES; g++) begin
      if (straps.gate_used[g]) begin
        straps.vector[straps.gate_line[g]] = 1'b1; // [R05]
      end
    end
  end
endmodule

// >>> rtl/aisel_top.sv
// card device select, status bit, vector and priority chain logic
`timescale 1ns/10ps
// Notes on behaviour
// [R01] separate destination and source address comparators
// [R02] each strapped bit must match its bus bit
// [R03] six-bit address against low six bus lines
// [R04] status on chosen line, same data index
// [R05] vector: at most four ones, others zero
// [R06] only the group's first address is driven
// [R07] processor stores counter at vector, resumes plus one
// [R08] shared status line, each card distinct vector
// [R09] slot daisy chain, leftmost highest priority
// [R10] pass grant only when granted and idle
module aisel_top
  import aisel_pkg::*;
#(
  parameter logic [ADDR_W-1:0] DEV_ADDR = ADDR_DEFAULT
)(
  input  wire logic                       SYS_CLK,
  input  wire logic                       RESET,
  input  wire logic [BUS_W-1:0]           DESTINATION_ADDRESS_BUS,
  input  wire logic [BUS_W-1:0]           SOURCE_ADDRESS_BUS,
  input  wire logic [SB_SEL_W-1:0]        STATUS_SELECT,
  input  wire logic [VEC_GATES-1:0]       VECTOR_GATE_USED,
  input  wire logic [VEC_GATES*GATE_SEL_W-1:0] VECTOR_GATE_LINE,
  input  wire logic                       IRQ_EVENT,
  input  wire logic                       IRQ_CLEAR,
  input  wire logic                       STATUS_READ,
  input  wire logic                       VECTOR_ACK,
  input  wire logic                       PRIORITY_CHAIN_IN,
  output logic                            PRIORITY_CHAIN_OUT,
  output logic                            DEST_SELECTED,
  output logic                            SOURCE_SELECTED,
  output logic                            IRQ_PENDING,
  output logic [SB_W-1:0]                 STATUS_BIT_LINES,
  output logic [BUS_W-1:0]                DATA_BUS_LINES,
  output logic                            DATA_BUS_OE_N
);
  aisel_if straps ();

  typedef enum logic [1:0] {
    AISEL_DRIVE_NONE   = 2'h0,
    AISEL_DRIVE_VECTOR = 2'h1,
    AISEL_DRIVE_STATUS = 2'h3
  } aisel_drive_t;

  aisel_state_t     state;
  aisel_state_t     next_state;
  aisel_drive_t     next_drive;
  logic             granted;
  logic             raise_req;
  logic             drop_req;
  logic             take_vector;
  logic             next_dest_sel;
  logic             next_src_sel;
  logic [SB_W-1:0]  next_status;
  logic [BUS_W-1:0] next_data;
  logic             next_oe_n;

  // per-bit strap compare on the low address lines
  function automatic logic addr_match(input logic [BUS_W-1:0] bus);
    logic [ADDR_W-1:0] bit_ok;
    bit_ok = '0;
    for (int b = 0; b < ADDR_W; b++) begin
      bit_ok[b] = (bus[b] == DEV_ADDR[b]); // [R02]
    end
    addr_match = &bit_ok; // [R03]
  endfunction

  // one-hot word, the chosen line carries the level
  function automatic logic [BUS_W-1:0] line_word(
    input logic [SB_SEL_W-1:0] idx,
    input logic                lvl
  );
    logic [BUS_W-1:0] word;
    word      = '0;
    word[idx] = lvl;
    line_word = word;
  endfunction

  // strap unpacking for the vector generator
  assign straps.gate_used = VECTOR_GATE_USED;
  for (genvar g = 0; g < VEC_GATES; g++) begin : g_lines
    assign straps.gate_line[g] =
      VECTOR_GATE_LINE[g*GATE_SEL_W +: GATE_SEL_W];
  end

  aisel_vecgen u_vecgen (
    .straps (straps.gen)
  );

  // address comparators, one per bus
  assign next_dest_sel = addr_match(DESTINATION_ADDRESS_BUS);
  assign next_src_sel  = addr_match(SOURCE_ADDRESS_BUS);

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      DEST_SELECTED <= 1'b0;
    end else begin
      DEST_SELECTED <= next_dest_sel; // [R01]
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      SOURCE_SELECTED <= 1'b0;
    end else begin
      SOURCE_SELECTED <= next_src_sel; // [R01]
    end
  end

  // request events
  assign granted     = PRIORITY_CHAIN_IN; // [R09]
  assign raise_req   = IRQ_EVENT;
  assign drop_req    = IRQ_CLEAR && !IRQ_EVENT;
  assign take_vector = VECTOR_ACK && granted && IRQ_PENDING;

  // request state: a new event wins over clear and ack
  always_comb begin
    next_state = state;
    unique case (state)
      AISEL_IDLE: begin
        if (raise_req) begin
          next_state = AISEL_PENDING;
        end
      end
      AISEL_PENDING: begin
        if (raise_req) begin
          next_state = AISEL_PENDING;
        end else if (take_vector) begin
          next_state = AISEL_ACKED;
        end else if (drop_req) begin
          next_state = AISEL_IDLE;
        end
      end
      AISEL_ACKED: begin
        if (raise_req) begin
          next_state = AISEL_PENDING;
        end else if (drop_req) begin
          next_state = AISEL_IDLE;
        end
      end
      default: begin
        next_state = AISEL_IDLE;
      end
    endcase
  end

  // request register
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state <= AISEL_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign IRQ_PENDING = (state == AISEL_PENDING);

  // chain passes only an idle grant
  assign PRIORITY_CHAIN_OUT = PRIORITY_CHAIN_IN && !IRQ_PENDING; // [R10]

  // data bus source: vector outranks status read
  always_comb begin
    next_drive = AISEL_DRIVE_NONE;
    if (take_vector) begin
      next_drive = AISEL_DRIVE_VECTOR;
    end else if (STATUS_READ) begin
      next_drive = AISEL_DRIVE_STATUS;
    end
  end

  // drive word and enable for the next cycle
  always_comb begin
    next_data = '0;
    next_oe_n = 1'b1;
    unique case (next_drive)
      AISEL_DRIVE_NONE: begin
        next_data = '0;
        next_oe_n = 1'b1;
      end
      AISEL_DRIVE_VECTOR: begin
        next_data = straps.vector; // [R06] [R08]
        next_oe_n = 1'b0;
      end
      AISEL_DRIVE_STATUS: begin
        next_data = line_word(STATUS_SELECT, IRQ_PENDING); // [R04]
        next_oe_n = 1'b0;
      end
      default: begin
        next_data = '0;
        next_oe_n = 1'b1;
      end
    endcase
  end

  assign next_status = line_word(STATUS_SELECT, IRQ_PENDING); // [R04]

  // status lines and data bus registers
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      STATUS_BIT_LINES <= '0;
    end else begin
      STATUS_BIT_LINES <= next_status;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      DATA_BUS_LINES <= '0;
    end else begin
      DATA_BUS_LINES <= next_data;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      DATA_BUS_OE_N <= 1'b1;
    end else begin
      DATA_BUS_OE_N <= next_oe_n;
    end
  end
endmodule

// >>> dv/aisel_host.sv
// host model: acks a pending card, keeps its resume address
`timescale 1ns/10ps
module aisel_host (
  input  wire logic        SYS_CLK,
  input  wire logic        en,
  input  wire logic        IRQ_PENDING,
  input  wire logic        DATA_BUS_OE_N,
  input  wire logic [15:0] DATA_BUS_LINES,
  output logic             VECTOR_ACK = 1'b0,
  output logic [15:0]      resume
);
  always @(posedge SYS_CLK) VECTOR_ACK <= #1 en && IRQ_PENDING;
  // only a driven word answering our ack is a vector
  always @(posedge SYS_CLK) begin
    if (!DATA_BUS_OE_N && VECTOR_ACK) begin
      resume <= DATA_BUS_LINES + 16'h0001;
    end
  end
endmodule

// >>> dv/aisel_asserts.sv
// checker for the card select and interrupt block
`timescale 1ns/10ps
module aisel_asserts
  import aisel_pkg::*;
#(
  parameter logic [ADDR_W-1:0] DEV_ADDR = ADDR_DEFAULT
)(
  input wire logic                SYS_CLK,
  input wire logic                RESET,
  input wire logic                IRQ_EVENT,
  input wire logic                IRQ_CLEAR,
  input wire logic                STATUS_READ,
  input wire logic                VECTOR_ACK,
  input wire logic                PRIORITY_CHAIN_IN,
  input wire logic                PRIORITY_CHAIN_OUT,
  input wire logic                DEST_SELECTED,
  input wire logic                SOURCE_SELECTED,
  input wire logic                IRQ_PENDING,
  input wire logic                DATA_BUS_OE_N,
  input wire logic [BUS_W-1:0]    DESTINATION_ADDRESS_BUS,
  input wire logic [BUS_W-1:0]    SOURCE_ADDRESS_BUS,
  input wire logic [BUS_W-1:0]    DATA_BUS_LINES,
  input wire logic [SB_W-1:0]     STATUS_BIT_LINES,
  input wire logic [SB_SEL_W-1:0] STATUS_SELECT
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  wire logic grant = VECTOR_ACK && PRIORITY_CHAIN_IN && IRQ_PENDING;
  a_dest_select: assert property (1 |=> DEST_SELECTED ==
    ($past(DESTINATION_ADDRESS_BUS[ADDR_W-1:0]) == DEV_ADDR))
    else $error("dest select wrong");
  a_src_select: assert property (1 |=> SOURCE_SELECTED ==
    ($past(SOURCE_ADDRESS_BUS[ADDR_W-1:0]) == DEV_ADDR))
    else $error("source select wrong");
  a_chain_pass: assert property (
    PRIORITY_CHAIN_OUT == (PRIORITY_CHAIN_IN && !IRQ_PENDING))
    else $error("chain pass wrong");
  a_event_pend: assert property (IRQ_EVENT |=> IRQ_PENDING)
    else $error("pend");
  a_status_line: assert property (1 |=> STATUS_BIT_LINES ==
    ($past(IRQ_PENDING) << $past(STATUS_SELECT))) else $error("status");
  a_vector_drive: assert property (grant |=> !DATA_BUS_OE_N &&
    (IRQ_PENDING == $past(IRQ_EVENT))) else $error("vector");
  a_ack_refused: assert property (VECTOR_ACK && !grant && !STATUS_READ
    |=> DATA_BUS_OE_N) else $error("refuse");
  a_vector_ones: assert property (grant |=>
    $countones(DATA_BUS_LINES) <= VEC_GATES) else $error("ones");
  a_clear_idle: assert property (IRQ_CLEAR && !IRQ_EVENT |=>
    !IRQ_PENDING) else $error("clear");
  cover property (grant);
  cover property (VECTOR_ACK && !PRIORITY_CHAIN_IN);
  cover property (DEST_SELECTED && SOURCE_SELECTED);
  cover property (STATUS_READ && IRQ_PENDING);
  cover property (IRQ_EVENT && IRQ_CLEAR && IRQ_PENDING);
endmodule
bind aisel_top aisel_asserts #(
  .DEV_ADDR (DEV_ADDR)
) i_aisel_asserts (
  .SYS_CLK                 (SYS_CLK),
  .RESET                   (RESET),
  .IRQ_EVENT               (IRQ_EVENT),
  .IRQ_CLEAR               (IRQ_CLEAR),
  .STATUS_READ             (STATUS_READ),
  .VECTOR_ACK              (VECTOR_ACK),
  .PRIORITY_CHAIN_IN       (PRIORITY_CHAIN_IN),
  .PRIORITY_CHAIN_OUT      (PRIORITY_CHAIN_OUT),
  .DEST_SELECTED           (DEST_SELECTED),
  .SOURCE_SELECTED         (SOURCE_SELECTED),
  .IRQ_PENDING             (IRQ_PENDING),
  .DATA_BUS_OE_N           (DATA_BUS_OE_N),
  .DESTINATION_ADDRESS_BUS (DESTINATION_ADDRESS_BUS),
  .SOURCE_ADDRESS_BUS      (SOURCE_ADDRESS_BUS),
  .DATA_BUS_LINES          (DATA_BUS_LINES),
  .STATUS_BIT_LINES        (STATUS_BIT_LINES),
  .STATUS_SELECT           (STATUS_SELECT)
);

// >>> dv/tb_aisel_top.sv
// self-checking bench for the card select and interrupt block
`timescale 1ns/10ps
module tb_aisel_top;
  import aisel_pkg::*;
  logic SYS_CLK = 0, RESET = 1, IRQ_EVENT = 0, IRQ_CLEAR = 0, en = 0;
  logic STATUS_READ = 0, PRIORITY_CHAIN_IN = 1, VECTOR_ACK, IRQ_PENDING;
  logic [15:0] DESTINATION_ADDRESS_BUS = 0, SOURCE_ADDRESS_BUS = 0, resume;
  logic [15:0] VECTOR_GATE_LINE = 16'hF520, DATA_BUS_LINES, STATUS_BIT_LINES;
  logic [3:0]  STATUS_SELECT = 4'h5, VECTOR_GATE_USED = 4'h7;
  logic PRIORITY_CHAIN_OUT, DEST_SELECTED, SOURCE_SELECTED, DATA_BUS_OE_N;
  int bad_count = 0, compares = 0, cycles = 0;
  always #4 SYS_CLK = ~SYS_CLK;
  aisel_top i_aisel_top (.*);
  aisel_host i_aisel_host (.*);
  task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task cyc(int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask
  task summarize;
    $display("bad_count %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task t_addr;
    logic [15:0] v [4];
    v = '{16'h0035, 16'hFF35, 16'h0034, 16'h0015};
    for (int i = 0; i < 4; i++) begin
      DESTINATION_ADDRESS_BUS = v[i];
      SOURCE_ADDRESS_BUS = ~v[i];
      cyc(1);
      chk("dest", DEST_SELECTED, i < 2);
      chk("src", SOURCE_SELECTED, 0);
    end
    SOURCE_ADDRESS_BUS = 16'hC035;
    DESTINATION_ADDRESS_BUS = 16'h0035;
    cyc(1);
    chk("both", {DEST_SELECTED, SOURCE_SELECTED}, 3);
  endtask
  task t_irq;
    int k;
    en = 1;
    IRQ_EVENT = 1;
    cyc(1);
    IRQ_EVENT = 0;
    chk("chain", PRIORITY_CHAIN_OUT, 0);
    cyc(1);
    chk("status", STATUS_BIT_LINES, 16'h0020);
    for (k = 0; k < 10 && DATA_BUS_OE_N; k++) cyc(1);
    chk("vector", DATA_BUS_LINES, 16'h0025);
    cyc(1);
    chk("resume", resume, 16'h0026);
    chk("pass", PRIORITY_CHAIN_OUT, 1);
    IRQ_CLEAR = 1;
    cyc(1);
    IRQ_CLEAR = 0;
  endtask
  task t_block;
    PRIORITY_CHAIN_IN = 0;
    IRQ_EVENT = 1;
    cyc(1);
    IRQ_EVENT = 0;
    cyc(6);
    chk("blocked", DATA_BUS_OE_N, 1);
    chk("chain", PRIORITY_CHAIN_OUT, 0);
  endtask
  task t_status;
    en = 0;
    STATUS_READ = 1;
    cyc(1);
    chk("stat_oe", DATA_BUS_OE_N, 0);
    chk("stat_word", DATA_BUS_LINES, 16'h0020);
    STATUS_READ = 0;
    IRQ_EVENT = 1;
    IRQ_CLEAR = 1;
    cyc(1);
    IRQ_EVENT = 0;
    chk("set_wins", IRQ_PENDING, 1);
    cyc(1);
    IRQ_CLEAR = 0;
    chk("cleared", IRQ_PENDING, 0);
    STATUS_READ = 1;
    cyc(1);
    STATUS_READ = 0;
    chk("stat_idle", DATA_BUS_LINES, 16'h0000);
    chk("stat_oe2", DATA_BUS_OE_N, 0);
  endtask
  always @(posedge SYS_CLK) if (++cycles == 500) begin
    bad_count++;
    summarize;
  end
  initial begin
    cyc(6);
    RESET = 0;
    t_addr;
    t_irq;
    t_block;
    t_status;
    summarize;
  end
endmodule
